/* dbsp_pkg.sv */
// Purpose: Shared constants and types for the DDR burst SRAM port model
// Assumes: System clock of 50 MHz samples every pin of the memory link
// Notes:   Word address is 20 bits, data word 18 bits in two 9-bit lanes
package dbsp_pkg;

	// ==========================================================
	// Geometry
	localparam int ADDR_W     = 20;
	localparam int WORD_W     = 18;
	localparam int LANES      = 2;
	localparam int LANE_W     = 9;
	localparam int FIFO_DEPTH = 32;

	// ==========================================================
	// Timing
	localparam int CLK_NS          = 20;
	localparam int DLL_STOP_NS     = 30;
	localparam int LINK_HALF_NS    = 80;
	localparam int DLL_GAP_CYC     = (LINK_HALF_NS + DLL_STOP_NS + CLK_NS - 1) / CLK_NS;
	localparam int DLL_LOCK_CYC    = 1024;
	localparam int IMP_PERIOD_CYC  = 1024;
	localparam int STRAP_SETTLE    = 3;

	localparam logic [10:0] DLL_LOCK_LAST = 11'(DLL_LOCK_CYC - 1);
	localparam logic [9:0]  IMP_LAST      = 10'(IMP_PERIOD_CYC - 1);
	localparam logic [2:0]  DLL_GAP_LIMIT = 3'(DLL_GAP_CYC);
	localparam logic [1:0]  STRAP_DONE    = 2'(STRAP_SETTLE);

	// ==========================================================
	// Reset values
	localparam logic RST_FIRST_WORD = 1'b1;

	// ==========================================================
	// Types
	typedef struct packed {
		logic                k;
		logic                kn;
		logic                c;
		logic                cn;
		logic                load_n;
		logic                rnw;
		logic                dll_en_n;
		logic [ADDR_W-1:0]   addr;
		logic [WORD_W-1:0]   dq;
		logic [LANES-1:0]    lanes_n;
	} dbsp_pins_t;

	typedef struct packed {
		logic                v;
		logic [ADDR_W-1:0]   addr;
		logic [WORD_W-1:0]   w0;
		logic [WORD_W-1:0]   w1;
		logic [LANES-1:0]    m0;
		logic [LANES-1:0]    m1;
	} dbsp_burst_t;

	typedef struct packed {
		dbsp_pins_t          s1;
		dbsp_pins_t          s2;
		logic                kp_prev;
		logic                kn_prev;
		logic                cp_prev;
		logic                cn_prev;
		logic [1:0]          strap_cnt;
		logic                single;
		logic                wr_arm;
		logic [ADDR_W-1:0]   wr_addr;
		logic                inf_v;
		logic [ADDR_W-1:0]   inf_addr;
		logic [WORD_W-1:0]   inf_w0;
		logic [LANES-1:0]    inf_m0;
		dbsp_burst_t         post;
		logic                rd_arm;
		logic [ADDR_W-1:0]   rd_addr;
		logic                push1;
		logic [WORD_W-1:0]   push1_w;
		logic                first;
		logic [WORD_W-1:0]   dq;
		logic                oe;
		logic                cq;
		logic                cqn;
		logic [10:0]         lock_cnt;
		logic                locked;
		logic [2:0]          gap_cnt;
		logic [9:0]          imp_cnt;
		logic                imp_upd;
	} dbsp_state_t;

endpackage

/* dbsp_port.sv */
// Notes on behaviour
// [R01] Write command: rnw low, load_n low at rising ref_p; address captured.
// [R02] Lowest address bit seeds a one-bit linear burst counter.
// [R03] First write word taken at next rising ref_p, gated by lane selects.
// [R04] Second word taken at following rising ref_n; burst then posted.
// [R05] A new write command is accepted on every rising ref_p.
// [R06] Deselected: pending writes finish, other inputs ignored.
// [R07] Active-low lane selects sampled per word; deasserted lanes keep contents.
// [R08] Both output clocks high at power-on selects single-clock mode, fixed.
// [R09] Controller leaves one NOP between a read and a following write.
// [R10] Write before read is posted and committed at the next write command.
// [R11] Read of the just-written address returns posted data, not array data.
// [R12] Controller gives each bank its own load_n.
// [R13] Output impedance update every 1024 clock cycles after power-up.
// [R14] Free-running echo clocks follow output clocks, or ref clocks if single.
// [R15] DLL enabled locks after 1024 stable clock cycles, also after restarts.
// [R16] Stopping or slowing ref clock for 30 ns resets the DLL.
// [R17] Controller keeps clock between 80 MHz and rated maximum with DLL on; the controller model runs the link at 6.25 MHz.
// [R18] DLL enable pin low: DLL off, one-cycle read latency.
// [R19] Read at t: first word at rising out_n t+1, second at out_p t+2.
// [R20] Second burst address is first address with lowest bit inverted.
// [R21] Power-up deselected with data outputs high impedance.
// [R22] Stopped clocks hold outputs; controller parks clocks for fast restart.
// [R23] Read command: rnw high, load_n low at rising ref_p; address captured.
// [R24] Read latency 1.5 cycles with DLL on, 1 cycle with DLL off.
// [R25] load_n high at rising ref_p is a NOP; bus returns to high impedance.
//
// Purpose: Device side of a DDR two-word burst SRAM port, pins sampled by clk_i
// Assumes: Link clocks far slower than clk_i; all pins pass two flip-flops
// Notes:   Read words queue in a FIFO and leave on output clock edges, or ref clock edges if single
`timescale 1ns/1ps

// ==========================================================
// Read data FIFO
module dbsp_fifo
#(
	parameter int W     = 18,
	parameter int DEPTH = 32
)
(
	input  wire logic         clk_i,
	input  wire logic         rst_i,
	input  wire logic         in_valid_i,
	output logic              in_ready_o,
	input  wire logic [W-1:0] in_data_i,
	output logic              out_valid_o,
	input  wire logic         out_ready_i,
	output logic [W-1:0]      out_data_o
);
	localparam int PW = $clog2(DEPTH);

	typedef struct packed {
		logic [PW:0] wp;
		logic [PW:0] rp;
	} dbsp_fifo_state_t;

	dbsp_fifo_state_t q;
	dbsp_fifo_state_t n;
	logic [W-1:0]     mem [DEPTH];

	assign out_valid_o = q.wp != q.rp;
	assign in_ready_o  = (q.wp[PW-1:0] != q.rp[PW-1:0]) || (q.wp[PW] == q.rp[PW]);
	assign out_data_o  = mem[q.rp[PW-1:0]];

	always_comb
	begin
		n = q;
		if (in_valid_i && in_ready_o)
			n.wp = q.wp + 1'b1;
		if (out_valid_o && out_ready_i)
			n.rp = q.rp + 1'b1;
	end

	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
			q <= '0;
		else
			q <= n;
	end

	always_ff @(posedge clk_i)
	begin
		if (in_valid_i && in_ready_o)
			mem[q.wp[PW-1:0]] <= in_data_i;
	end
endmodule

// ==========================================================
// Port top
module dbsp_port
	import dbsp_pkg::*;
(
	input  wire logic              clk_i,
	input  wire logic              rst_i,
	input  wire logic              in_ref_p_i,
	input  wire logic              in_ref_n_i,
	input  wire logic              out_timing_p_i,
	input  wire logic              out_timing_n_i,
	input  wire logic              load_n_i,
	input  wire logic              read_not_write_i,
	input  wire logic              dll_enable_n_i,
	input  wire logic [ADDR_W-1:0] addr_i,
	input  wire logic [WORD_W-1:0] dq_i,
	input  wire logic [LANES-1:0]  byte_lane_sel_n_i,
	output logic [WORD_W-1:0]      dq_o,
	output logic                   dq_oe_o,
	output logic                   return_strobe_p_o,
	output logic                   return_strobe_n_o,
	output logic                   dll_locked_o,
	output logic                   imp_update_o
);
	function automatic logic [ADDR_W-1:0] dbsp_partner(input logic [ADDR_W-1:0] a);
		return {a[ADDR_W-1:1], ~a[0]};
	endfunction

	function automatic logic [WORD_W-1:0] dbsp_merge(input logic [WORD_W-1:0] base,
		input dbsp_burst_t p, input logic [ADDR_W-1:0] a);
		logic [WORD_W-1:0] w;
		logic [LANES-1:0]  m;
		w = (a[0] == p.addr[0]) ? p.w0 : p.w1;
		m = (a[0] == p.addr[0]) ? p.m0 : p.m1;
		for (int l = 0; l < LANES; l++)
			if (p.v && p.addr[ADDR_W-1:1] == a[ADDR_W-1:1] && m[l])
				base[l*LANE_W +: LANE_W] = w[l*LANE_W +: LANE_W];
		return base;
	endfunction

	dbsp_state_t       q;
	dbsp_state_t       n;
	dbsp_pins_t        pins;
	logic [WORD_W-1:0] mem [1 << ADDR_W];
	logic              kp, kn, op, on, out_edge, dll_on, cmd_wr, cmd_rd;
	logic              commit, pop, rd_fire;
	logic              fifo_in_valid, fifo_in_ready, fifo_out_valid;
	logic [WORD_W-1:0] fifo_in_data, fifo_out_data, word0, word1;

	assign pins = '{k: in_ref_p_i, kn: in_ref_n_i, c: out_timing_p_i, cn: out_timing_n_i,
		load_n: load_n_i, rnw: read_not_write_i, dll_en_n: dll_enable_n_i,
		addr: addr_i, dq: dq_i, lanes_n: byte_lane_sel_n_i};

	// ==========================================================
	// Edge detection on sampled link clocks
	assign kp       = q.s2.k & ~q.kp_prev;
	assign kn       = q.s2.kn & ~q.kn_prev;
	assign op       = q.single ? kp : (q.s2.c & ~q.cp_prev);
	assign on       = q.single ? kn : (q.s2.cn & ~q.cn_prev);
	assign out_edge = op | on;
	assign dll_on   = q.s2.dll_en_n;
	assign cmd_wr   = kp & ~q.s2.load_n & ~q.s2.rnw;       // [R01] [R05]
	assign cmd_rd   = kp & ~q.s2.load_n & q.s2.rnw;        // [R23]

	dbsp_fifo #(.W(WORD_W), .DEPTH(FIFO_DEPTH)) u_fifo (
		.clk_i       (clk_i),
		.rst_i       (rst_i),
		.in_valid_i  (fifo_in_valid),
		.in_ready_o  (fifo_in_ready),
		.in_data_i   (fifo_in_data),
		.out_valid_o (fifo_out_valid),
		.out_ready_i (pop),
		.out_data_o  (fifo_out_data)
	);

	always_comb
	begin
		n             = q;
		commit        = 1'b0;
		rd_fire       = 1'b0;
		word0         = '0;
		word1         = '0;
		n.s1          = pins;
		n.s2          = q.s1;
		n.kp_prev     = q.s2.k;
		n.kn_prev     = q.s2.kn;
		n.cp_prev     = q.s2.c;
		n.cn_prev     = q.s2.cn;
		// Strap caught once the synchroniser holds real pin levels
		if (q.strap_cnt != STRAP_DONE)
		begin
			n.strap_cnt = q.strap_cnt + 2'h1;
			if (q.strap_cnt == STRAP_DONE - 2'h1)
				n.single = q.s2.c & q.s2.cn;                 // [R08]
		end
		// Write command and first data word; a NOP still takes a pending write's first word
		if (kp)
		begin
			n.inf_v = q.wr_arm;                              // [R06] [R25]
			if (q.wr_arm)
			begin
				n.inf_addr = q.wr_addr;
				n.inf_w0   = q.s2.dq;                        // [R03]
				n.inf_m0   = ~q.s2.lanes_n;                  // [R07]
			end
			n.wr_arm  = cmd_wr;
			n.wr_addr = q.s2.addr;                           // [R01]
			n.rd_arm  = cmd_rd;
			n.rd_addr = q.s2.addr;                           // [R23]
			if (cmd_wr && q.post.v)
			begin
				commit   = 1'b1;                             // [R10]
				n.post.v = 1'b0;
			end
		end
		if (q.push1 && fifo_in_ready)
			n.push1 = 1'b0;
		// Second data word completes the burst into the posted register
		if (kn)
		begin
			if (q.inf_v)
			begin
				// Older burst goes to the array before the newer one replaces it
				if (q.post.v)
					commit = 1'b1;                           // [R05] [R10]
				n.post = '{v: 1'b1, addr: q.inf_addr, w0: q.inf_w0, w1: q.s2.dq,
					m0: q.inf_m0, m1: ~q.s2.lanes_n};        // [R04] [R07]
				n.inf_v = 1'b0;
			end
			if (q.rd_arm && !q.push1)
			begin
				word0   = dbsp_merge(mem[q.rd_addr], q.post, q.rd_addr);
				word0   = dbsp_merge(word0, n.post, q.rd_addr);              // [R11]
				word1   = dbsp_merge(mem[dbsp_partner(q.rd_addr)], q.post,
					dbsp_partner(q.rd_addr));
				word1   = dbsp_merge(word1, n.post, dbsp_partner(q.rd_addr)); // [R02] [R20]
				rd_fire = 1'b1;
				n.push1   = fifo_in_ready;
				n.push1_w = word1;
				n.rd_arm  = 1'b0;
			end
		end
		fifo_in_valid = rd_fire | q.push1;
		fifo_in_data  = q.push1 ? q.push1_w : word0;
		// First word of a burst waits for the edge set by the latency mode
		pop = fifo_out_valid & out_edge & (~q.first | (dll_on ? on : op));  // [R19] [R24]
		if (pop)
		begin
			n.dq    = fifo_out_data;
			n.oe    = 1'b1;
			n.first = ~q.first;
		end
		else if (out_edge)
			n.oe = 1'b0;                                     // [R25]
		n.cq  = q.single ? q.s2.k : q.s2.c;                  // [R14]
		n.cqn = q.single ? q.s2.kn : q.s2.cn;
		// DLL lock tracking
		n.gap_cnt = (kp | kn) ? 3'h0 : q.gap_cnt + {2'h0, q.gap_cnt != DLL_GAP_LIMIT};
		if (!dll_on || q.gap_cnt == DLL_GAP_LIMIT)
		begin
			n.lock_cnt = '0;                                 // [R16] [R18]
			n.locked   = 1'b0;
		end
		else if (kp)
		begin
			if (q.lock_cnt == DLL_LOCK_LAST)
				n.locked = 1'b1;                             // [R15]
			else
				n.lock_cnt = q.lock_cnt + 11'h1;
		end
		n.imp_upd = kp && q.imp_cnt == IMP_LAST;             // [R13]
		if (kp)
			n.imp_cnt = q.imp_cnt + 10'h1;
	end

	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			q       <= '0;                                   // [R21]
			q.first <= RST_FIRST_WORD;
		end
		else
			q <= n;
	end

	// ==========================================================
	// Array commit of a posted burst, lane by lane
	always_ff @(posedge clk_i)
	begin
		if (commit)
			for (int l = 0; l < LANES; l++)
			begin
				if (q.post.m0[l])
					mem[q.post.addr][l*LANE_W +: LANE_W] <= q.post.w0[l*LANE_W +: LANE_W];
				if (q.post.m1[l])
					mem[dbsp_partner(q.post.addr)][l*LANE_W +: LANE_W] <=
						q.post.w1[l*LANE_W +: LANE_W];           // [R02] [R07]
			end
	end

	assign dq_o              = q.dq;
	assign dq_oe_o           = q.oe;
	assign return_strobe_p_o = q.cq;
	assign return_strobe_n_o = q.cqn;
	assign dll_locked_o      = q.locked;
	assign imp_update_o      = q.imp_upd;

	// ==========================================================
	// Assertions
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	a_pop_on_edge: assert property (pop |-> out_edge)       // [R19]
		else $error("read word left without an output clock edge");
	a_first_word_edge: assert property (pop && q.first |-> (dll_on ? on : op))  // [R24]
		else $error("first burst word on wrong output edge");
	a_data_from_queue: assert property (pop |=> dq_o == $past(fifo_out_data) && dq_oe_o)
		else $error("driven word does not match queued word");      // [R19]
	a_hiz_idle_edge: assert property (out_edge && !pop |=> !dq_oe_o)  // [R25]
		else $error("data bus still driven after idle output edge");
	a_wr_addr_capture: assert property (cmd_wr |=> q.wr_arm && q.wr_addr == $past(q.s2.addr))
		else $error("write address not captured");                  // [R01]
	a_post_commit: assert property (cmd_wr && q.post.v |-> commit ##1 !q.post.v || kn)
		else $error("posted burst not committed on write command"); // [R10]
	a_post_kept: assert property (q.post.v && !cmd_wr |=> q.post.v)  // [R10]
		else $error("posted burst lost without commit");
	a_burst_word2: assert property (kn && q.inf_v |=> q.post.v && q.post.w1 == $past(q.s2.dq))
		else $error("second write word not captured");              // [R04]
	a_echo_follow: assert property (!q.single |=> return_strobe_p_o == $past(q.s2.c))
		else $error("echo clock does not follow output clock");     // [R14]
	a_strap_fixed: assert property (q.strap_cnt == STRAP_DONE |=> $stable(q.single))
		else $error("single-clock strap changed in operation");     // [R08]
	a_dll_off: assert property (!dll_on |=> !dll_locked_o)          // [R18]
		else $error("DLL reports lock while disabled");
	a_dll_gap: assert property (q.gap_cnt == DLL_GAP_LIMIT |=> !dll_locked_o)
		else $error("DLL lock survived stopped clock");             // [R16]
	a_imp_pulse: assert property (imp_update_o |-> q.imp_cnt == 10'h0 ##1 !imp_update_o)
		else $error("impedance update off its period");             // [R13]

	c_read_burst: cover property (pop && q.first ##[1:40] pop);
	c_write_commit: cover property (commit);
	c_read_bypass: cover property (rd_fire && n.post.v && n.post.addr[ADDR_W-1:1] ==
		q.rd_addr[ADDR_W-1:1]);
	c_dll_lock: cover property ($rose(dll_locked_o));
endmodule

/* dbsp_ctrl_model.sv */
// Purpose: Memory controller model driving the link pins of the port
// Assumes: Link cycle of eight system clocks, output clocks lead by one
// Notes:   Read words and echo levels are captured at fixed link steps
`timescale 1ns/1ps

// ==========================================================
// Controller model
module dbsp_ctrl_model
	import dbsp_pkg::*;
(
	input  wire logic              clk_i,
	input  wire logic              strap_hi_i,
	input  wire logic              out_stop_i,
	input  wire logic [WORD_W-1:0] dq_i,
	input  wire logic              dq_oe_i,
	input  wire logic              strobe_p_i,
	output logic                   ref_p_o,
	output logic                   ref_n_o,
	output wire logic              out_p_o,
	output wire logic              out_n_o,
	output logic                   load_n_o,
	output logic                   rnw_o,
	output logic [ADDR_W-1:0]      addr_o,
	output logic [WORD_W-1:0]      dq_o,
	output logic [LANES-1:0]       lanes_n_o
);
	logic [WORD_W:0]   cap_n;
	logic [WORD_W:0]   cap_p;
	logic [7:0]        echo;
	logic [3:0]        step;
	logic              op;
	logic              on;
	logic              pend;
	logic [WORD_W-1:0] pw0;
	logic [WORD_W-1:0] pw1;
	logic [LANES-1:0]  pm0;
	logic [LANES-1:0]  pm1;

	initial
	begin
		ref_p_o = 1'h0;
		ref_n_o = 1'h1;
		op = 1'h0;
		on = 1'h1;
		load_n_o = 1'h1;
		rnw_o = 1'h0;
		addr_o = '0;
		dq_o = '0;
		lanes_n_o = '1;
		pend = 1'h0;
		step = 4'h8;
	end

	assign out_p_o = op | strap_hi_i;
	assign out_n_o = on | strap_hi_i;

	always @(negedge clk_i)
	begin
		if (step == 4'h0)
			cap_n <= {dq_oe_i, dq_i};
		if (step == 4'h4)
			cap_p <= {dq_oe_i, dq_i};
		if (step < 4'h8)
			echo[step[2:0]] <= strobe_p_i;
	end

	// ==========================================================
	// One link cycle: command at ref_p rise, previous write's data
	task automatic cyc(input logic ld, rw, input logic [ADDR_W-1:0] a,
		input logic [WORD_W-1:0] w0, w1, input logic [LANES-1:0] m0, m1);
		for (int s = 0; s < 8; s++)
		begin
			@(posedge clk_i);
			step <= 4'(s);
			if (!out_stop_i && (s == 3 || s == 7))
			begin
				op <= (s == 7);
				on <= (s == 3);
			end
			if (s == 0)
			begin
				ref_p_o <= 1'h1;
				ref_n_o <= 1'h0;
				load_n_o <= ld;
				rnw_o <= rw;
				addr_o <= a;
			end
			if (s == 0 || s == 4)
			begin
				dq_o <= pend ? (s == 0 ? pw0 : pw1) : ~dq_o;
				lanes_n_o <= pend ? (s == 0 ? pm0 : pm1) : ~lanes_n_o;
			end
			if (s == 4)
			begin
				ref_p_o <= 1'h0;
				ref_n_o <= 1'h1;
				rnw_o <= ~rw;
				addr_o <= ~a;
			end
		end
		pend = !ld && !rw;
		pw0 = w0;
		pw1 = w1;
		pm0 = m0;
		pm1 = m1;
	endtask

	// Park input clocks equal and output clocks high
	task halt(input int n);
		@(posedge clk_i);
		ref_p_o <= 1'h0;
		ref_n_o <= 1'h0;
		op <= 1'h1;
		on <= 1'h1;
		step <= 4'h8;
		repeat (n) @(posedge clk_i);
	endtask
endmodule

/* dbsp_port_tb.sv */
// Purpose: Self-checking bench for the DDR burst SRAM port
// Assumes: Controller model issues one command per link cycle
// Notes:   A read issued in link cycle t is judged after cycle t+2, its first word after t+1 with the DLL off
`timescale 1ns/1ps

// ==========================================================
// Bench top
module dbsp_port_tb
	import dbsp_pkg::*;
();
	logic              clk_i = 1'h0;
	logic              rst_i = 1'h1;
	logic              strap_hi = 1'h1;
	logic              out_stop = 1'h1;
	logic              dll_n = 1'h1;
	logic              ref_p, ref_n, out_p, out_n, load_n, rnw;
	logic [ADDR_W-1:0] addr;
	logic [WORD_W-1:0] ctl_dq, dev_dq, dq_bus;
	logic [LANES-1:0]  lanes_n;
	logic              dev_oe, strobe_p, strobe_n, locked, imp_pulse;
	int                n_errors = 0, checked = 0, cyc_cnt = 0, n_imp = 0;

	assign dq_bus = dev_oe ? dev_dq : ctl_dq;

	dbsp_port uut (.clk_i(clk_i), .rst_i(rst_i), .in_ref_p_i(ref_p), .in_ref_n_i(ref_n),
		.out_timing_p_i(out_p), .out_timing_n_i(out_n), .load_n_i(load_n),
		.read_not_write_i(rnw), .dll_enable_n_i(dll_n), .addr_i(addr), .dq_i(dq_bus),
		.byte_lane_sel_n_i(lanes_n), .dq_o(dev_dq), .dq_oe_o(dev_oe),
		.return_strobe_p_o(strobe_p), .return_strobe_n_o(strobe_n), .dll_locked_o(locked),
		.imp_update_o(imp_pulse));

	dbsp_ctrl_model ctrl (.clk_i(clk_i), .strap_hi_i(strap_hi), .out_stop_i(out_stop),
		.dq_i(dq_bus), .dq_oe_i(dev_oe), .strobe_p_i(strobe_p), .ref_p_o(ref_p),
		.ref_n_o(ref_n), .out_p_o(out_p), .out_n_o(out_n), .load_n_o(load_n),
		.rnw_o(rnw), .addr_o(addr), .dq_o(ctl_dq), .lanes_n_o(lanes_n));

	initial
		forever #(CLK_NS / 2) clk_i = ~clk_i;

	always @(posedge clk_i)
	begin
		cyc_cnt <= cyc_cnt + 1;
		n_imp <= rst_i ? 0 : n_imp + int'(imp_pulse === 1'h1);
		if (cyc_cnt == 25000)
		begin
			n_errors++;
			stop_test;
		end
	end

	// ==========================================================
	// Shared tasks
	task stop_test;
		if (n_errors == 0 && checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task chk(input logic [WORD_W:0] got, input logic [WORD_W:0] exp);
		checked++;
		if (got !== exp)
		begin
			n_errors++;
			$display("ERROR %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task nop;
		ctrl.cyc(1'h1, 1'h0, '0, '0, '0, '1, '1);
	endtask

	task rd(input logic [ADDR_W-1:0] a);
		ctrl.cyc(1'h0, 1'h1, a, '0, '0, '1, '1);
	endtask

	task wr(input logic [ADDR_W-1:0] a, input logic [WORD_W-1:0] w0, w1,
		input logic [LANES-1:0] m0, m1);
		ctrl.cyc(1'h0, 1'h0, a, w0, w1, m0, m1);
	endtask

	task pair(input logic [WORD_W-1:0] e0, e1);
		chk(ctrl.cap_n, {1'h1, e0});
		chk(ctrl.cap_p, {1'h1, e1});
	endtask

	task do_reset(input logic strap);
		@(posedge clk_i);
		rst_i <= 1'h1;
		strap_hi <= strap;
		out_stop <= strap;
		repeat (8) @(posedge clk_i);
		rst_i <= 1'h0;
		repeat (6) @(posedge clk_i);
		strap_hi <= 1'h0;
		nop;
		nop;
	endtask

	// ==========================================================
	// Scenarios
	task t_single;
		nop;
		chk(19'({ctrl.echo[6], ctrl.echo[2]}), 19'h2);
		chk(19'(ctrl.cap_n[WORD_W]), 19'h0);
	endtask

	task t_dll;
		repeat (1018) nop;
		chk(19'({ctrl.echo[7], ctrl.echo[3]}), 19'h1);
		chk(19'(strobe_n), 19'h1);
		chk(19'(locked), 19'h0);
		chk(19'(n_imp), 19'h0);
		repeat (8) nop;
		chk(19'(locked), 19'h1);
		chk(19'(n_imp), 19'h1);
		ctrl.halt(16);
		chk(19'(locked), 19'h0);
		repeat (1028) nop;
		chk(19'(locked), 19'h1);
		chk(19'(n_imp), 19'h2);
	endtask

	task t_wr_rd;
		wr(20'h00010, 18'h2a5a5, 18'h15a5a, 2'h0, 2'h0);
		rd(20'h00010);
		nop;
		nop;
		pair(18'h2a5a5, 18'h15a5a);
		wr(20'h00031, 18'h01111, 18'h02222, 2'h0, 2'h0);
		nop;
		rd(20'h00031);
		rd(20'h00030);
		nop;
		pair(18'h01111, 18'h02222);
		rd(20'h00010);
		pair(18'h02222, 18'h01111);
		nop;
		nop;
		pair(18'h2a5a5, 18'h15a5a);
		nop;
		chk(19'(ctrl.cap_n[WORD_W]), 19'h0);
	endtask

	task t_lanes;
		wr(20'h00040, 18'h3ffff, 18'h3ffff, 2'h0, 2'h0);
		wr(20'h00040, 18'h00000, 18'h00000, 2'h2, 2'h1);
		rd(20'h00040);
		nop;
		nop;
		pair(18'h3fe00, 18'h001ff);
		nop;
	endtask

	task t_b2b;
		for (int i = 0; i < 3; i++)
			wr(20'h00050 + 20'(2 * i), 18'h0aa00 + 18'(i), 18'h05500 + 18'(i), 2'h0, 2'h0);
		nop;
		for (int i = 0; i < 5; i++)
		begin
			if (i < 3)
				rd(20'h00050 + 20'(2 * i));
			else
				nop;
			if (i >= 2)
				pair(18'h0aa00 + 18'(i - 2), 18'h05500 + 18'(i - 2));
		end
		nop;
	endtask

	task t_dll_off;
		dll_n <= 1'h0;
		nop;
		wr(20'h00060, 18'h12345, 18'h0abcd, 2'h0, 2'h0);
		nop;
		rd(20'h00060);
		nop;
		chk(ctrl.cap_p, {1'h1, 18'h12345});
		nop;
		chk(ctrl.cap_n, {1'h1, 18'h0abcd});
		dll_n <= 1'h1;
	endtask

	task t_fifo;
		out_stop <= 1'h1;
		repeat (20) rd(20'h00060);
		nop;
		nop;
		chk(19'(ctrl.cap_n[WORD_W]), 19'h0);
		out_stop <= 1'h0;
		nop;
		repeat (16)
		begin
			nop;
			pair(18'h12345, 18'h0abcd);
		end
		nop;
		chk(19'(ctrl.cap_n[WORD_W]), 19'h0);
	endtask

	initial
	begin
		do_reset(1'h1);
		t_single;
		do_reset(1'h0);
		t_dll;
		t_wr_rd;
		t_lanes;
		t_b2b;
		t_dll_off;
		t_fifo;
		stop_test;
	end
endmodule
